// ---- verilog/efc_fifo.sv ----
/*
 * Embedded FIFO cell with full, empty and threshold flags, selectable
 * depth, nine-bit parity and an active-low pointer reset, plus a small
 * register port carrying sticky events, a mask and the fill level.
 * Assumes one system clock; the write and read side clocks, strobes and
 * all other cell pins except nrst_i and the register port arrive asynchronously and are sampled in here.
 */
`default_nettype none
`include "efc_defines.svh"

// Functional notes
// - Writes are ignored while full; contents and write pointer stay put.
// - Reads are ignored while empty; read pointer and read side stay put.
// - Pointer reset sets empty, clears counters, zeroes read word and parity error outputs, keeps memory.
// - Read happens only with read select and read pulse both low.
// - Write happens only with write select and write pulse both low.
// - Word is nine bits; with generation on, the top bit is made here.
// - Parity is odd when the sense input is high, even when low.
// - Separate active-high parity error outputs for read and write sides.
// - Equal flag at fill equal to threshold; at-or-above flag at fill >= threshold.
// - Three-bit depth select gives a capacity of two to the select plus one.
// - Threshold stays eight bits; FIFOs deeper than 256 words offset the threshold by one word.
// - At 256 deep, the most the three-bit select gives, the equal flag fires at threshold words.
// - A write to the word being read refreshes the read output.
// - Write side follows the write clock, read side the read clock.
module efc_fifo #(
	parameter int MEM_AW = `EFC_MEM_AW
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic wr_side_clock_i,
	input wire logic rd_side_clock_i,
	input wire logic wr_block_sel_n_i,
	input wire logic wr_pulse_n_i,
	input wire logic rd_block_sel_n_i,
	input wire logic rd_pulse_n_i,
	input wire logic ptr_reset_n_i,
	input wire logic [`EFC_WORD_W-1:0] write_word_i,
	input wire logic [`EFC_LEVEL_W-1:0] threshold_level_i,
	input wire logic [`EFC_DSEL_W-1:0] depth_log_sel_i,
	input wire logic odd_parity_sel_i,
	input wire logic parity_gen_en_i,
	input wire logic [`EFC_REG_ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic irq_o,
	output logic [`EFC_WORD_W-1:0] read_word_o,
	output logic full_o,
	output logic empty_o,
	output logic at_threshold_flag_o,
	output logic above_or_at_threshold_flag_o,
	output logic rd_parity_err_o,
	output logic wr_parity_err_o
);

	localparam int CW = MEM_AW + 1;
	localparam int MEM_WORDS = 1 << MEM_AW;
	localparam int PIN_W = 7 + `EFC_WORD_W + `EFC_LEVEL_W + `EFC_DSEL_W + 2;
	// Idle pin levels: side clocks and data low, strobes, selects and reset high.
	// A side clock reset high would show a false rising edge after reset.
	localparam logic [PIN_W-1:0] PIN_RST = {2'b00, 5'b11111, {(PIN_W - 7) {1'b0}}};

	// Synchronised pins
	logic [PIN_W-1:0] pin_q;
	logic wr_clk_q;
	logic rd_clk_q;
	logic wr_sel_n_q;
	logic wr_pulse_n_q;
	logic rd_sel_n_q;
	logic rd_pulse_n_q;
	logic ptr_reset_n_q;
	logic [`EFC_WORD_W-1:0] word_q;
	logic [`EFC_LEVEL_W-1:0] level_q;
	logic [`EFC_DSEL_W-1:0] dsel_q;
	logic odd_q;
	logic gen_q;

	// Core state
	logic wr_clk_d_reg;
	logic rd_clk_d_reg;
	logic wr_pulse_d_reg;
	logic armed_reg;
	logic [MEM_AW-1:0] wr_ptr_reg;
	logic [MEM_AW-1:0] rd_ptr_reg;
	logic [MEM_AW-1:0] rd_loc_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic [`EFC_WORD_W-1:0] mem [MEM_WORDS];
	efc_pkg::efc_rd_state_t rd_state_reg;

	// Register port state
	logic [`EFC_EV_W-1:0] status_reg;
	logic [`EFC_EV_W-1:0] status_next;
	logic [`EFC_EV_W-1:0] mask_reg;
	logic [`EFC_EV_W-1:0] events;

	// Combinational terms
	logic ptr_rst;
	logic wr_edge;
	logic rd_edge;
	logic wr_try;
	logic rd_try;
	logic wr_go;
	logic rd_go;
	logic [CW-1:0] depth_words;
	logic [MEM_AW-1:0] ptr_mask;
	logic [CW-1:0] thr_words;
	logic [`EFC_WORD_W-1:0] stored_word;
	logic [`EFC_WORD_W-1:0] read_src;
	logic wr_gen_bit;
	logic wr_par_bad;
	logic rd_gen_unused;
	logic rd_par_bad;
	logic refresh_hit;
	logic full_next;
	logic empty_next;

	efc_sync #(
		.W(PIN_W),
		.RST_VAL(PIN_RST)
	) u_pin_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.d_i({wr_side_clock_i, rd_side_clock_i, wr_block_sel_n_i, wr_pulse_n_i,
			rd_block_sel_n_i, rd_pulse_n_i, ptr_reset_n_i, write_word_i,
			threshold_level_i, depth_log_sel_i, odd_parity_sel_i, parity_gen_en_i}),
		.q_o(pin_q)
	);

	assign {wr_clk_q, rd_clk_q, wr_sel_n_q, wr_pulse_n_q, rd_sel_n_q, rd_pulse_n_q,
		ptr_reset_n_q, word_q, level_q, dsel_q, odd_q, gen_q} = pin_q;

	// Capacity 2**(sel+1), held to what the storage can hold
	function automatic logic [CW-1:0] depth_of(input logic [`EFC_DSEL_W-1:0] sel);
		int lg;
		lg = int'(sel) + 1;
		if (lg > MEM_AW) begin
			lg = MEM_AW;
		end
		return CW'(1) << lg;
	endfunction : depth_of

	assign ptr_rst = ~ptr_reset_n_q;
	assign depth_words = depth_of(dsel_q);
	assign ptr_mask = MEM_AW'(depth_words - CW'(1));

	// Side clocks only act on their own rising edges
	assign wr_edge = wr_clk_q & ~wr_clk_d_reg;
	assign rd_edge = rd_clk_q & ~rd_clk_d_reg;
	assign wr_try = wr_edge & ~wr_sel_n_q & ~wr_pulse_n_q;
	assign rd_try = rd_edge & ~rd_sel_n_q & ~rd_pulse_n_q;
	// Flags are registered alongside the count, so gating sees the same state
	assign wr_go = wr_try & ~full_o & armed_reg & ~ptr_rst;
	assign rd_go = rd_try & ~empty_o & ~ptr_rst;

	efc_parity u_wr_par (
		.word_i(word_q),
		.odd_i(odd_q),
		.gen_bit_o(wr_gen_bit),
		.err_o(wr_par_bad)
	);

	assign stored_word = {gen_q ? wr_gen_bit : word_q[`EFC_PAR_BIT],
		word_q[`EFC_PAR_BIT-1:0]};

	// Storage is not touched by pointer reset
	always_ff @(posedge clk_i) begin
		if (wr_go) begin
			mem[wr_ptr_reg] <= stored_word;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_clk_d_reg <= 1'b0;
			rd_clk_d_reg <= 1'b0;
			wr_pulse_d_reg <= 1'b1;
		end else begin
			wr_clk_d_reg <= wr_clk_q;
			rd_clk_d_reg <= rd_clk_q;
			wr_pulse_d_reg <= wr_pulse_n_q;
		end
	end

	// A write pulse held low across pointer reset would otherwise slip in
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			armed_reg <= 1'b0;
		end else if (ptr_rst) begin
			armed_reg <= 1'b0;
		end else if (wr_pulse_d_reg && !wr_pulse_n_q) begin
			armed_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i || ptr_rst) begin
			wr_ptr_reg <= '0;
		end else if (wr_go) begin
			wr_ptr_reg <= (wr_ptr_reg + MEM_AW'(1)) & ptr_mask;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i || ptr_rst) begin
			rd_ptr_reg <= '0;
		end else if (rd_go) begin
			rd_ptr_reg <= (rd_ptr_reg + MEM_AW'(1)) & ptr_mask;
		end
	end

	always_comb begin
		count_next = count_reg;
		if (ptr_rst) begin
			count_next = '0;
		end else if (wr_go && !rd_go) begin
			count_next = count_reg + CW'(1);
		end else if (rd_go && !wr_go) begin
			count_next = count_reg - CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// The eight-bit level counts from one only on depths above 256 words
	assign thr_words = (depth_words > CW'(`EFC_THR_FINE_MAX)) ?
		CW'(level_q) + CW'(1) : CW'(level_q);
	assign full_next = (count_next >= depth_words);
	assign empty_next = (count_next == '0);

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			full_o <= 1'b0;
			empty_o <= 1'b1;
			at_threshold_flag_o <= 1'b0;
			above_or_at_threshold_flag_o <= 1'b0;
		end else begin
			full_o <= full_next;
			empty_o <= empty_next;
			at_threshold_flag_o <= (count_next == thr_words);
			above_or_at_threshold_flag_o <= (count_next >= thr_words);
		end
	end

	// Read cycle stays open while the accepted strobe is still low
	always_ff @(posedge clk_i) begin
		if (!nrst_i || ptr_rst) begin
			rd_state_reg <= efc_pkg::EFC_RD_IDLE;
		end else begin
			unique case (rd_state_reg)
				efc_pkg::EFC_RD_IDLE: begin
					if (rd_go) begin
						rd_state_reg <= efc_pkg::EFC_RD_OPEN;
					end
				end
				efc_pkg::EFC_RD_OPEN: begin
					if (rd_pulse_n_q || rd_sel_n_q) begin
						rd_state_reg <= efc_pkg::EFC_RD_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i || ptr_rst) begin
			rd_loc_reg <= '0;
		end else if (rd_go) begin
			rd_loc_reg <= rd_ptr_reg;
		end
	end

	// A new pop takes priority over refreshing the word already shown
	assign refresh_hit = (rd_state_reg == efc_pkg::EFC_RD_OPEN) && wr_go &&
		(wr_ptr_reg == rd_loc_reg) && !rd_go;
	assign read_src = refresh_hit ? stored_word : mem[rd_ptr_reg];

	efc_parity u_rd_par (
		.word_i(read_src),
		.odd_i(odd_q),
		.gen_bit_o(rd_gen_unused),
		.err_o(rd_par_bad)
	);

	always_ff @(posedge clk_i) begin
		if (!nrst_i || ptr_rst) begin
			read_word_o <= `EFC_WORD_RST;
			rd_parity_err_o <= 1'b0;
		end else if (rd_go || refresh_hit) begin
			read_word_o <= read_src;
			rd_parity_err_o <= rd_par_bad;
		end
	end

	// With generation on, the write check has nothing to compare against
	always_ff @(posedge clk_i) begin
		if (!nrst_i || ptr_rst) begin
			wr_parity_err_o <= 1'b0;
		end else if (wr_go) begin
			wr_parity_err_o <= wr_par_bad & ~gen_q;
		end
	end

	always_comb begin
		events = '0;
		events[`EFC_EV_WR_REFUSED] = wr_try & ~wr_go;
		events[`EFC_EV_RD_REFUSED] = rd_try & ~rd_go;
		events[`EFC_EV_WR_PAR] = wr_go & wr_par_bad & ~gen_q;
		events[`EFC_EV_RD_PAR] = (rd_go | refresh_hit) & rd_par_bad;
		events[`EFC_EV_FULL] = full_next & ~full_o;
		events[`EFC_EV_EMPTY] = empty_next & ~empty_o;
	end

	// Read of status clears it, but an event in that same cycle survives
	always_comb begin
		status_next = status_reg;
		if (reg_rd_i && reg_addr_i == `EFC_REG_STATUS) begin
			status_next = '0;
		end
		status_next = status_next | events;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mask_reg <= `EFC_MASK_RST;
		end else if (reg_wr_i && reg_addr_i == `EFC_REG_MASK) begin
			mask_reg <= reg_wdata_i[`EFC_EV_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_next & mask_reg);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`EFC_REG_STATUS: reg_rdata_o <= 32'(status_reg);
				`EFC_REG_MASK: reg_rdata_o <= 32'(mask_reg);
				`EFC_REG_FILL: reg_rdata_o <= 32'(count_reg);
				`EFC_REG_FLAGS: reg_rdata_o <= 32'({above_or_at_threshold_flag_o,
					at_threshold_flag_o, full_o, empty_o});
				default: reg_rdata_o <= '0;
			endcase
		end else begin
			reg_rdata_o <= '0;
		end
	end

endmodule : efc_fifo

`default_nettype wire

// ---- inc/efc_defines.svh ----
/*
 * Constants of the embedded FIFO flag control block: register offsets,
 * status bit positions, reset values and structural limits.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef EFC_DEFINES_SVH
`define EFC_DEFINES_SVH

// Register port offsets (word index on the plain register port)
`define EFC_REG_STATUS 4'h0
`define EFC_REG_MASK 4'h1
`define EFC_REG_FILL 4'h2
`define EFC_REG_FLAGS 4'h3
`define EFC_REG_ADDR_W 4

// Status and mask bit positions
`define EFC_EV_WR_REFUSED 0
`define EFC_EV_RD_REFUSED 1
`define EFC_EV_WR_PAR 2
`define EFC_EV_RD_PAR 3
`define EFC_EV_FULL 4
`define EFC_EV_EMPTY 5
`define EFC_EV_W 6

// Reset values
`define EFC_MASK_RST 6'h00
`define EFC_WORD_RST 9'h000

// Word layout
`define EFC_WORD_W 9
`define EFC_PAR_BIT 8
`define EFC_LEVEL_W 8
`define EFC_DSEL_W 3

// Depths above this use the shifted threshold count
`define EFC_THR_FINE_MAX 256

// Default storage address width, 2**8 words
`define EFC_MEM_AW 8

`endif

// ---- inc/efc_pkg.sv ----
/*
 * Types of the embedded FIFO flag control block.
 * Assumes efc_defines.svh is on the include path.
 */
`default_nettype none

package efc_pkg;

	// Read-cycle tracker: open while a read strobe that was accepted is held low
	typedef enum logic [1:0] {
		EFC_RD_IDLE = 2'b01,
		EFC_RD_OPEN = 2'b10
	} efc_rd_state_t;

endpackage : efc_pkg

`default_nettype wire

// ---- verilog/efc_sync.sv ----
/*
 * Three-stage synchroniser for a bus of pin inputs.
 * Assumes each bit is an independent level; an output bit changes only
 * once the second and third stages agree.
 */
`default_nettype none

module efc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (!nrst_i) begin
					q_o[i] <= RST_VAL[i];
				end else if (s2_reg[i] == s3_reg[i]) begin
					q_o[i] <= s3_reg[i];
				end
			end
		end
	endgenerate

endmodule : efc_sync

`default_nettype wire

// ---- verilog/efc_parity.sv ----
/*
 * Parity generator and checker for one nine-bit word.
 * Assumes the caller registers the outputs it needs.
 */
`default_nettype none
`include "efc_defines.svh"

module efc_parity (
	input wire logic [`EFC_WORD_W-1:0] word_i,
	input wire logic odd_i,
	output logic gen_bit_o,
	output logic err_o
);

	// Odd sense: the nine bits together must hold an odd count of ones
	assign gen_bit_o = (^word_i[`EFC_PAR_BIT-1:0]) ^ odd_i;
	assign err_o = (^word_i) ^ odd_i;

endmodule : efc_parity

`default_nettype wire

// ---- tb/efc_fifo_asserts.sv ----
/*
 * Concurrent checks on the pins of the embedded FIFO cell.
 * Assumes odd_parity_sel_i changes only while read_word_o is zero.
 */
`default_nettype none
`include "efc_defines.svh"

module efc_fifo_asserts (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic wr_pulse_n_i,
	input wire logic rd_pulse_n_i,
	input wire logic ptr_reset_n_i,
	input wire logic [`EFC_LEVEL_W-1:0] threshold_level_i,
	input wire logic odd_parity_sel_i,
	input wire logic [`EFC_WORD_W-1:0] read_word_o,
	input wire logic full_o,
	input wire logic empty_o,
	input wire logic at_threshold_flag_o,
	input wire logic above_or_at_threshold_flag_o,
	input wire logic rd_parity_err_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	a_full_not_empty: assert property (full_o |-> !empty_o)
		else $error("full and empty together");
	a_eq_needs_geq: assert property (at_threshold_flag_o |-> above_or_at_threshold_flag_o)
		else $error("equal flag without at-or-above flag");
	// The level pin needs a few cycles through the synchronisers
	a_empty_below_thr: assert property ($stable(threshold_level_i)[*8] ##0
		(empty_o && threshold_level_i != 8'h00) |-> !above_or_at_threshold_flag_o)
		else $error("at-or-above flag while empty");
	// Eight quiet cycles outlast the pin synchronisers
	a_full_stays_full: assert property ((full_o && rd_pulse_n_i && ptr_reset_n_i)[*8]
		|=> full_o)
		else $error("full dropped without a read");
	a_empty_stays_empty: assert property ((empty_o && wr_pulse_n_i && ptr_reset_n_i)[*8]
		|=> empty_o)
		else $error("empty dropped without a write");
	a_empty_word_held: assert property ((empty_o && wr_pulse_n_i && ptr_reset_n_i)[*8]
		|=> $stable(read_word_o))
		else $error("read word moved while empty");
	a_ptr_reset_clears: assert property (!ptr_reset_n_i [*7]
		|-> empty_o && read_word_o == 9'h000 && !rd_parity_err_o)
		else $error("pointer reset did not clear");
	a_rd_parity_match: assert property ($stable(odd_parity_sel_i)[*8] ##0 read_word_o != 9'h000
		|-> rd_parity_err_o == ((^read_word_o) ^ odd_parity_sel_i))
		else $error("read parity flag wrong");

	c_full: cover property ($rose(full_o));
	c_irq: cover property ($rose(irq_o));
	c_rd_par: cover property ($rose(rd_parity_err_o));
endmodule : efc_fifo_asserts

bind efc_fifo efc_fifo_asserts u_chk (.clk_i, .nrst_i, .wr_pulse_n_i, .rd_pulse_n_i,
	.ptr_reset_n_i, .threshold_level_i, .odd_parity_sel_i, .read_word_o, .full_o, .empty_o,
	.at_threshold_flag_o, .above_or_at_threshold_flag_o, .rd_parity_err_o, .irq_o);

`default_nettype wire

// ---- tb/efc_user.sv ----
/*
 * User logic that drives the cell's write and read side pins.
 * Assumes the cell samples pins on clk_i; every level is held at least 5 cycles.
 */
`default_nettype none

module efc_user (
	input wire logic clk_i,
	output logic wclk_o = 1'b0,
	output logic rclk_o = 1'b0,
	output logic wsel_n_o = 1'b1,
	output logic wpul_n_o = 1'b1,
	output logic rsel_n_o = 1'b1,
	output logic rpul_n_o = 1'b1,
	output logic ptr_n_o = 1'b1,
	output logic [8:0] word_o = 9'h000
);
	timeunit 1ns;
	timeprecision 1ps;
	// Five cycles outlast the synchronisers, so no access lands while a flag clears
	task automatic hold;
		repeat (5) @(posedge clk_i);
	endtask : hold
	// The pulse falls on every write, which also re-arms after pointer reset
	task do_write(input logic [8:0] w, input logic sel_n);
		@(posedge clk_i);
		word_o <= w;
		wsel_n_o <= sel_n;
		wpul_n_o <= 1'b0;
		hold;
		wclk_o <= 1'b1;
		hold;
		wclk_o <= 1'b0;
		wsel_n_o <= 1'b1;
		wpul_n_o <= 1'b1;
		word_o <= ~w;
		hold;
	endtask : do_write
	task do_read(input logic sel_n);
		@(posedge clk_i);
		rsel_n_o <= sel_n;
		rpul_n_o <= 1'b0;
		hold;
		rclk_o <= 1'b1;
		hold;
		rclk_o <= 1'b0;
		rsel_n_o <= 1'b1;
		rpul_n_o <= 1'b1;
		hold;
	endtask : do_read
	task ptr_reset;
		@(posedge clk_i);
		ptr_n_o <= 1'b0;
		hold;
		hold;
		ptr_n_o <= 1'b1;
		hold;
	endtask : ptr_reset
endmodule : efc_user

`default_nettype wire

// ---- tb/embedded_fifo_flag_control_bench.sv ----
/*
 * Self-checking bench for the FIFO cell against a queue model.
 * Assumes the cell at default MEM_AW, so no shifted threshold count.
 */
`default_nettype none
`include "efc_defines.svh"

module embedded_fifo_flag_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic wclk, rclk, wsel_n, wpul_n, rsel_n, rpul_n, ptr_n;
	logic [8:0] wword, rword, w, last;
	logic [7:0] thr = 8'h01;
	logic [2:0] dsel = 3'h1;
	logic odd = 1'b0;
	logic gen = 1'b0;
	logic lv = 1'b0;
	logic [3:0] rd_addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata, d;
	logic rwr = 1'b0;
	logic rrd = 1'b0;
	logic irq, full, empty, eq, geq, rd_parity_err, wr_parity_err;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	int depth = 4;
	logic [8:0] q[$];

	always #5 clk_i = ~clk_i;

	efc_user usr (.clk_i(clk_i), .wclk_o(wclk), .rclk_o(rclk), .wsel_n_o(wsel_n),
		.wpul_n_o(wpul_n), .rsel_n_o(rsel_n), .rpul_n_o(rpul_n), .ptr_n_o(ptr_n),
		.word_o(wword));
	efc_fifo uut (.clk_i(clk_i), .nrst_i(nrst_i), .wr_side_clock_i(wclk),
		.rd_side_clock_i(rclk), .wr_block_sel_n_i(wsel_n), .wr_pulse_n_i(wpul_n),
		.rd_block_sel_n_i(rsel_n), .rd_pulse_n_i(rpul_n), .ptr_reset_n_i(ptr_n),
		.write_word_i(wword), .threshold_level_i(thr), .depth_log_sel_i(dsel),
		.odd_parity_sel_i(odd), .parity_gen_en_i(gen), .reg_addr_i(rd_addr),
		.reg_wdata_i(wdata), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata),
		.irq_o(irq), .read_word_o(rword), .full_o(full), .empty_o(empty),
		.at_threshold_flag_o(eq), .above_or_at_threshold_flag_o(geq),
		.rd_parity_err_o(rd_parity_err), .wr_parity_err_o(wr_parity_err));

	task give_verdict;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task flags;
		chk({full, empty, eq, geq}, {q.size() == depth, q.size() == 0,
			q.size() == thr, q.size() >= thr});
	endtask : flags

	task push(input logic sel_n);
		w = 9'($urandom);
		gen <= 1'($urandom);
		usr.do_write(w, sel_n);
		if (!sel_n && q.size() < depth) begin
			chk(wr_parity_err, gen ? 1'b0 : (^w) ^ odd);
			if (gen)
				w[8] = (^w[7:0]) ^ odd;
			q.push_back(w);
		end
		flags;
	endtask : push

	task pop(input logic sel_n);
		usr.do_read(sel_n);
		if (!sel_n && q.size() > 0) begin
			last = q.pop_front();
			lv = 1'b1;
		end
		chk(rword, last);
		if (lv)
			chk(rd_parity_err, (^last) ^ odd);
		flags;
	endtask : pop

	// Full FIFO: a write lands on the word just popped while the read pulse is low
	task refresh;
		w = 9'($urandom);
		fork
			usr.do_read(1'b0);
			begin
				repeat (3) @(posedge clk_i);
				usr.do_write(w, 1'b0);
			end
		join
		chk(wr_parity_err, gen ? 1'b0 : (^w) ^ odd);
		if (gen)
			w[8] = (^w[7:0]) ^ odd;
		void'(q.pop_front());
		q.push_back(w);
		last = w;
		lv = 1'b1;
		chk(rword, last);
		chk(rd_parity_err, (^last) ^ odd);
		flags;
	endtask : refresh

	task reg_wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		rd_addr <= a;
		wdata <= v;
		rwr <= 1'b1;
		@(posedge clk_i);
		rwr <= 1'b0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe
	task reg_rd(input logic [3:0] a);
		@(posedge clk_i);
		rd_addr <= a;
		rrd <= 1'b1;
		@(posedge clk_i);
		rrd <= 1'b0;
		@(negedge clk_i);
		d = rdata;
	endtask : reg_rd

	initial begin
		void'($urandom(44));
		dsel = 3'($urandom_range(2));
		depth = 2 << dsel;
		thr = 8'($urandom_range(depth, 1));
		odd = 1'($urandom);
		last = 9'h000;
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		flags;
		push(1'b1);
		repeat (depth + 1) push(1'b0);
		refresh();
		reg_rd(`EFC_REG_FILL);
		chk(d, 32'(q.size()));
		pop(1'b1);
		repeat (depth + 1) pop(1'b0);
		push(1'b0);
		push(1'b0);
		usr.ptr_reset();
		q.delete();
		lv = 1'b0;
		last = 9'h000;
		chk({rword, rd_parity_err}, 10'h000);
		flags;
		odd <= ~odd;
		push(1'b0);
		pop(1'b0);
		reg_rd(`EFC_REG_STATUS);
		reg_wr(`EFC_REG_MASK, 32'h3);
		reg_rd(`EFC_REG_MASK);
		chk(d, 32'h3);
		pop(1'b0);
		chk(irq, 1'b1);
		reg_rd(`EFC_REG_FLAGS);
		chk(d, 32'({q.size() >= thr, q.size() == thr,
			q.size() == depth, q.size() == 0}));
		reg_rd(`EFC_REG_STATUS);
		chk(d & 32'h3, 32'h2);
		@(negedge clk_i);
		chk(irq, 1'b0);
		reg_rd(4'hF);
		chk(d, 32'h0);
		give_verdict;
	end
endmodule : embedded_fifo_flag_control_bench

`default_nettype wire
